// ===== logic/dpa_alu_shifter.sv
// Purpose: data-processing execution: operand shifter, alu, flag update
// Assumes: operands and instruction are loaded over classic wishbone
// Notes:   a write to the instruction register starts one execution
// Contract
// - execute only when flags meet condition
// - failed condition changes no register or flag
// - codes 0010-0111 are the six arithmetic ops
// - and, xor, or, pass, bit clear, invert
// - test codes update flags, never destination
// - immediate bit picks shifted register or immediate
// - flags change only with flag-update bit
// - logical ops: carry from shifter, overflow kept
// - arithmetic ops: alu carry and signed overflow
// - immediate left shift zero fills, last out carries
// - left shift by zero passes, old carry
// - immediate right shift zero means thirty-two
// - arithmetic shift fills sign, zero means thirty-two
// - rotate zero means extended rotate through carry
// - register amount low byte; zero passes through
// - register amount 1-31 matches immediate form
// - logical shifts by 32 and beyond
// - arithmetic shift 32 or more gives sign
// - rotate 32 unchanged, larger reduced by 32
// - bit 7 set with register shift: not ours
// - immediate rotated right by twice field
// - program counter destination, saved status on set
// - program counter reads plus 8 or 12
`timescale 1ns/1ps
module dpa_alu_shifter (
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         ce_i,
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [dpa_pkg::ADR_W-1:0]    wb_adr_i,
   input  wire logic [3:0]                   wb_sel_i,
   input  wire logic [dpa_pkg::DAT_W-1:0]    wb_dat_i,
   output logic      [dpa_pkg::DAT_W-1:0]    wb_dat_o,
   output logic                              wb_ack_o,
   output logic                              done_o
);
   import dpa_pkg::*;

   logic [31:0]        instr;
   logic [31:0]        op_first;
   logic [31:0]        op_shifted;
   logic [31:0]        op_amount;
   logic [31:0]        pc_addr;
   logic [31:0]        csw;
   logic [31:0]        ssw;
   logic [31:0]        result;
   logic [INFO_W-1:0]  info;
   logic               go;
   logic [31:0]        next_instr;
   logic [31:0]        next_op_first;
   logic [31:0]        next_op_shifted;
   logic [31:0]        next_op_amount;
   logic [31:0]        next_pc_addr;
   logic [31:0]        next_csw;
   logic [31:0]        next_ssw;
   logic [31:0]        next_result;
   logic [INFO_W-1:0]  next_info;
   logic               next_go;
   logic               next_done;
   logic               next_ack;
   logic [31:0]        next_dat;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int k = 0; k < 4; k++) begin
         if (sel[k]) begin
            r[8*k +: 8] = nw[8*k +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic cond_ok(input logic [3:0] cc, input dpa_flags_t f);
      logic r;
      case (cc[3:1])
         3'h0:    r = f.z;
         3'h1:    r = f.c;
         3'h2:    r = f.n;
         3'h3:    r = f.v;
         3'h4:    r = f.c & ~f.z;
         3'h5:    r = (f.n == f.v);
         3'h6:    r = ~f.z & (f.n == f.v);
         default: r = 1'b1;
      endcase
      // the reserved code never executes
      if (cc == 4'hf) begin
         return 1'b0;
      end
      return cc[0] ? ~r : r;
   endfunction

   // a 64-bit window keeps the out-shifted bit next to the result, so the
   // amounts of 32 and beyond need no cases of their own
   function automatic dpa_shres_t shift_op(input logic [31:0] m,
                                           input dpa_shift_t  t,
                                           input logic [7:0]  amt,
                                           input logic        cf,
                                           input logic        imm);
      logic [63:0] w;
      logic [7:0]  eff;
      dpa_shres_t  r;
      w   = 64'h0;
      eff = amt;
      r   = '{val: m, c: cf};
      if (imm && amt == 8'h00 && (t == logical_right_shift ||
                                  t == arithmetic_right_shift)) begin
         eff = SHIFT_FULL;
      end
      if (imm && amt == 8'h00 && t == rotate_right) begin
         r = '{val: {cf, m[31:1]}, c: m[0]};
      end else if (eff != 8'h00) begin
         case (t)
            logical_left_shift: begin
               w     = {32'h0, m} << eff;
               r.val = w[31:0];
               r.c   = w[32];
            end
            logical_right_shift: begin
               w     = {m, 32'h0} >> eff;
               r.val = w[63:32];
               r.c   = w[31];
            end
            arithmetic_right_shift: begin
               w     = 64'($signed({m, 32'h0}) >>> eff);
               r.val = w[63:32];
               r.c   = w[31];
            end
            default: begin
               w     = {m, m} >> eff[4:0];
               r.val = w[31:0];
               r.c   = w[31];
            end
         endcase
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // decode and operands

   dpa_flags_t  flags;
   dpa_op_t     opc;
   dpa_shift_t  stype;
   logic        i_bit;
   logic        s_bit;
   logic        rs_mode;
   logic [3:0]  rd;
   logic [31:0] pc_read;
   logic [31:0] a;
   logic [31:0] m;
   logic [3:0]  rot;
   logic [63:0] imm_w;
   dpa_shres_t  sh;
   dpa_shres_t  op2;
   logic        dp_ok;
   logic        pass;
   logic        is_test;
   logic        arith;

   assign flags   = dpa_flags_t'(csw[31:FLAGS_LO]);
   assign opc     = dpa_op_t'(instr[OPC_HI:OPC_LO]);
   assign stype   = dpa_shift_t'(instr[STYPE_LO +: 2]);
   assign i_bit   = instr[IMM_BIT];
   assign s_bit   = instr[SET_BIT];
   assign rs_mode = ~i_bit & instr[REGSHIFT_BIT];
   assign rd      = instr[RD_LO +: 4];
   assign pc_read = pc_addr + (rs_mode ? PC_AHEAD_REG : PC_AHEAD_IMM);
   assign a       = (instr[RN_LO +: 4] == PC_INDEX) ? pc_read : op_first;
   assign m       = (instr[3:0] == PC_INDEX) ? pc_read : op_shifted;
   assign sh      = shift_op(m, stype,
                             rs_mode ? op_amount[7:0] : {3'h0, instr[AMT_LO +: 5]},
                             flags.c, ~rs_mode);
   assign rot     = instr[ROT_LO +: 4];
   assign imm_w   = {24'h0, instr[7:0], 24'h0, instr[7:0]} >> {rot, 1'b0};
   assign op2     = i_bit ? '{val: imm_w[31:0], c: (rot == 4'h0) ? flags.c : imm_w[31]}
                          : sh;
   // a multiply or undefined pattern is not ours to execute
   assign dp_ok   = (instr[CLASS_HI:CLASS_LO] == CLASS_DP) &&
                    !(rs_mode && instr[MUL_BIT]);
   assign pass    = cond_ok(instr[COND_HI:COND_LO], flags);
   assign is_test = (instr[OPC_HI -: 2] == 2'h2);
   assign arith   = (instr[OPC_HI:OPC_LO] inside {[4'h2:4'h7], 4'ha, 4'hb});

   ////////////////////////////////////////////////////////////////////////////
   // alu

   logic [31:0] x;
   logic [31:0] y;
   logic        cin;
   logic [31:0] lres;
   logic [32:0] sum;
   logic [31:0] alu_res;
   dpa_flags_t  new_flags;

   always_comb begin
      x    = a;
      y    = op2.val;
      cin  = 1'b0;
      lres = 32'h0;
      case (opc)
         op_sub, compare_op: begin
            y   = ~op2.val;
            cin = 1'b1;
         end
         reverse_difference_op: begin
            x   = op2.val;
            y   = ~a;
            cin = 1'b1;
         end
         op_add_carry:             cin = flags.c;
         difference_with_carry_op: begin
            y   = ~op2.val;
            cin = flags.c;
         end
         reverse_difference_with_carry_op: begin
            x   = op2.val;
            y   = ~a;
            cin = flags.c;
         end
         op_and, and_test_op:               lres = a & op2.val;
         exclusive_or_op, equality_test_op: lres = a ^ op2.val;
         inclusive_or_op:  lres = a | op2.val;
         pass_operand_op:  lres = op2.val;
         bit_clear_op:     lres = a & ~op2.val;
         inverted_pass_op: lres = ~op2.val;
         default: ;
      endcase
      sum         = {1'b0, x} + {1'b0, y} + {32'h0, cin};
      alu_res     = arith ? sum[31:0] : lres;
      new_flags.n = alu_res[31];
      new_flags.z = (alu_res == 32'h0);
      new_flags.c = arith ? sum[32] : op2.c;
      new_flags.v = arith ? ((x[31] == y[31]) && (sum[31] != x[31]))
                          : flags.v;
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus and register state

   logic        wr_fire;
   logic [7:0]  wadr;
   assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   assign wadr    = {wb_adr_i[7:2], 2'h0};

   always_comb begin
      next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (wadr)
         ADR_INSTR:   next_dat = instr;
         ADR_FIRST:   next_dat = op_first;
         ADR_SHIFTED: next_dat = op_shifted;
         ADR_AMOUNT:  next_dat = op_amount;
         ADR_PC:      next_dat = pc_addr;
         ADR_CSW:     next_dat = csw;
         ADR_SSW:     next_dat = ssw;
         ADR_RESULT:  next_dat = result;
         ADR_INFO:    next_dat = {{(32-INFO_W){1'b0}}, info};
         default:     next_dat = 32'h0;
      endcase
      if (!next_ack) begin
         next_dat = wb_dat_o;
      end
   end

   always_comb begin
      next_instr      = instr;
      next_op_first   = op_first;
      next_op_shifted = op_shifted;
      next_op_amount  = op_amount;
      next_pc_addr    = pc_addr;
      next_csw        = csw;
      next_ssw        = ssw;
      next_result     = result;
      next_info       = info;
      next_go         = 1'b0;
      next_done       = 1'b0;
      if (wr_fire) begin
         case (wadr)
            ADR_INSTR: begin
               next_instr = merge(instr, wb_dat_i, wb_sel_i);
               next_go    = 1'b1;
            end
            ADR_FIRST:   next_op_first   = merge(op_first, wb_dat_i, wb_sel_i);
            ADR_SHIFTED: next_op_shifted = merge(op_shifted, wb_dat_i, wb_sel_i);
            ADR_AMOUNT:  next_op_amount  = merge(op_amount, wb_dat_i, wb_sel_i);
            ADR_PC:      next_pc_addr    = merge(pc_addr, wb_dat_i, wb_sel_i);
            ADR_CSW:     next_csw        = merge(csw, wb_dat_i, wb_sel_i);
            ADR_SSW:     next_ssw        = merge(ssw, wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
      // execution runs the cycle after the instruction write, when ack is
      // low and no bus write can fire, so it never meets a register write
      if (go) begin
         next_done = 1'b1;
         next_info = '0;
         if (!dp_ok) begin
            next_info[INFO_NOT_DP] = 1'b1;
         end else if (!pass) begin
            next_info[INFO_SKIPPED] = 1'b1;
         end else begin
            next_info[INFO_EXEC] = 1'b1;
            if (!is_test) begin
               next_result           = alu_res;
               next_info[INFO_WROTE] = 1'b1;
            end
            if (!is_test && rd == PC_INDEX) begin
               next_pc_addr        = alu_res;
               next_info[INFO_PCW] = 1'b1;
               if (s_bit) begin
                  next_csw = ssw;
               end
            end else if (s_bit) begin
               next_csw[31:FLAGS_LO] = new_flags;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         instr      <= INSTR_RST;
         op_first   <= WORD_RST;
         op_shifted <= WORD_RST;
         op_amount  <= WORD_RST;
         pc_addr    <= WORD_RST;
         csw        <= CSW_RST;
         ssw        <= SSW_RST;
         result     <= WORD_RST;
         info       <= '0;
         go         <= 1'b0;
         done_o     <= 1'b0;
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= WORD_RST;
      end else if (ce_i) begin
         instr      <= next_instr;
         op_first   <= next_op_first;
         op_shifted <= next_op_shifted;
         op_amount  <= next_op_amount;
         pc_addr    <= next_pc_addr;
         csw        <= next_csw;
         ssw        <= next_ssw;
         result     <= next_result;
         info       <= next_info;
         go         <= next_go;
         done_o     <= next_done;
         wb_ack_o   <= next_ack;
         wb_dat_o   <= next_dat;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic run;
   assign run = go & ce_i;

   sequence s_exec_ok;
      run && dp_ok && pass;
   endsequence

   chk_cond_fail_hold: assert property (run && !pass |=>
      csw == $past(csw) && result == $past(result) && pc_addr == $past(pc_addr))
      else $error("failed condition changed state");
   chk_test_no_dest: assert property (s_exec_ok and is_test |=>
      result == $past(result) && !info[INFO_WROTE])
      else $error("test operation wrote destination");
   chk_no_set_hold: assert property (s_exec_ok and !s_bit |=>
      csw == $past(csw))
      else $error("flags changed without update bit");
   chk_logic_v_kept: assert property (s_exec_ok and s_bit && !arith && rd != PC_INDEX
      |=> csw[FLAGS_LO] == $past(csw[FLAGS_LO]) && csw[29] == $past(op2.c))
      else $error("logical flag update wrong");
   chk_arith_carry: assert property (s_exec_ok and s_bit && arith && !is_test
      && rd != PC_INDEX |=> csw[29] == $past(sum[32]) && result == $past(sum[31:0]))
      else $error("arithmetic carry wrong");
   chk_lsr_full: assert property (!rs_mode && !i_bit && stype == logical_right_shift
      && instr[AMT_LO +: 5] == 5'h0 |-> sh.val == 32'h0 && sh.c == m[31])
      else $error("right shift by zero not 32");
   chk_asr_full: assert property (!rs_mode && !i_bit && stype == arithmetic_right_shift
      && instr[AMT_LO +: 5] == 5'h0 |-> sh.val == {32{m[31]}} && sh.c == m[31])
      else $error("arithmetic shift by zero not 32");
   chk_rrx_form: assert property (!rs_mode && stype == rotate_right
      && instr[AMT_LO +: 5] == 5'h0 |-> sh.val == {flags.c, m[31:1]} && sh.c == m[0])
      else $error("extended rotate wrong");
   chk_lsl_zero: assert property (stype == logical_left_shift && (rs_mode ?
      op_amount[7:0] == 8'h0 : instr[AMT_LO +: 5] == 5'h0) |-> sh.val == m && sh.c == flags.c)
      else $error("shift by zero not passthrough");
   chk_pc_restore: assert property (s_exec_ok and !is_test && rd == PC_INDEX && s_bit
      |=> csw == $past(ssw) && pc_addr == $past(alu_res))
      else $error("pc write did not restore status");
   chk_not_dp_idle: assert property (run && !dp_ok |=> info[INFO_NOT_DP]
      && result == $past(result) && csw == $past(csw))
      else $error("multiply pattern executed");
   chk_ack_once: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
endmodule

// ===== logic/dpa_pkg.sv
// Purpose: shared constants and types of the data-processing alu/shifter
// Assumes: 32-bit data, wishbone byte addresses on an 8-bit bus address
// Notes:   flags sit in the top nibble of both status words
package dpa_pkg;
   localparam int          ADR_W          = 8;
   localparam int          DAT_W          = 32;
   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0]  ADR_INSTR      = 8'h00;
   localparam logic [7:0]  ADR_FIRST      = 8'h04;
   localparam logic [7:0]  ADR_SHIFTED    = 8'h08;
   localparam logic [7:0]  ADR_AMOUNT     = 8'h0c;
   localparam logic [7:0]  ADR_PC         = 8'h10;
   localparam logic [7:0]  ADR_CSW        = 8'h14;
   localparam logic [7:0]  ADR_SSW        = 8'h18;
   localparam logic [7:0]  ADR_RESULT     = 8'h1c;
   localparam logic [7:0]  ADR_INFO       = 8'h20;
   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [31:0] INSTR_RST      = 32'h0000_0000;
   localparam logic [31:0] CSW_RST        = 32'h0000_0000;
   localparam logic [31:0] SSW_RST        = 32'h0000_0000;
   localparam logic [31:0] WORD_RST       = 32'h0000_0000;
   ////////////////////////////////////////////////////////////////////////////
   // instruction fields and status word fields
   localparam int          COND_HI        = 31;
   localparam int          COND_LO        = 28;
   localparam int          CLASS_HI       = 27;
   localparam int          CLASS_LO       = 26;
   localparam int          IMM_BIT        = 25;
   localparam int          OPC_HI         = 24;
   localparam int          OPC_LO         = 21;
   localparam int          SET_BIT        = 20;
   localparam int          RN_LO          = 16;
   localparam int          RD_LO          = 12;
   localparam int          AMT_LO         = 7;
   localparam int          MUL_BIT        = 7;
   localparam int          STYPE_LO       = 5;
   localparam int          REGSHIFT_BIT   = 4;
   localparam int          ROT_LO         = 8;
   localparam int          FLAGS_LO       = 28;
   localparam logic [3:0]  PC_INDEX       = 4'hf;
   localparam logic [1:0]  CLASS_DP       = 2'h0;
   localparam logic [31:0] PC_AHEAD_IMM   = 32'h0000_0008;
   localparam logic [31:0] PC_AHEAD_REG   = 32'h0000_000c;
   localparam logic [7:0]  SHIFT_FULL     = 8'h20;
   ////////////////////////////////////////////////////////////////////////////
   // info register bits
   localparam int          INFO_W         = 5;
   localparam int          INFO_EXEC      = 0;
   localparam int          INFO_WROTE     = 1;
   localparam int          INFO_PCW       = 2;
   localparam int          INFO_NOT_DP    = 3;
   localparam int          INFO_SKIPPED   = 4;
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [3:0] {
      op_and                          = 4'h0,
      exclusive_or_op                 = 4'h1,
      op_sub                          = 4'h2,
      reverse_difference_op           = 4'h3,
      op_add                          = 4'h4,
      op_add_carry                    = 4'h5,
      difference_with_carry_op        = 4'h6,
      reverse_difference_with_carry_op = 4'h7,
      and_test_op                     = 4'h8,
      equality_test_op                = 4'h9,
      compare_op                      = 4'ha,
      compare_negated_op              = 4'hb,
      inclusive_or_op                 = 4'hc,
      pass_operand_op                 = 4'hd,
      bit_clear_op                    = 4'he,
      inverted_pass_op                = 4'hf
   } dpa_op_t;

   typedef enum logic [1:0] {
      logical_left_shift     = 2'h0,
      logical_right_shift    = 2'h1,
      arithmetic_right_shift = 2'h2,
      rotate_right           = 2'h3
   } dpa_shift_t;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } dpa_flags_t;

   typedef struct packed {
      logic [31:0] val;
      logic        c;
   } dpa_shres_t;
endpackage

// ===== verification/test_data_processing_alu_shifter.sv
// Purpose: self-checking bench of the data-processing alu/shifter
// Assumes: ce_i high; operands loaded and results read over classic wishbone
// Notes:   reads queue their expected word, a monitor compares it at ack
`timescale 1ns/1ps
module test_data_processing_alu_shifter;
   import dpa_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, ack, done, sb;
   logic [7:0]  adr;
   logic [3:0]  f, op;
   logic [35:0] e;
   logic [31:0] dat, rdat, a, b, q[$];
   int          err_total, checked, k;
   int          seed = 8413;
   dpa_alu_shifter dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .done_o(done));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch read_data expected %h seen %h", exp, seen);
      end
   endtask
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0 && q.size() > 0) check(rdat, q.pop_front());
   end
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= ad;
      dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) err_total++;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] x);
      q.push_back(x);
      bus(1'b0, ad, 32'h0);
   endtask
   // operands first, instruction last: its write starts the execution
   task automatic setup(input logic [31:0] ins, x, y, am, input logic [3:0] fl);
      int n;
      n = 0;
      bus(1'b1, ADR_FIRST, x);
      bus(1'b1, ADR_SHIFTED, y);
      bus(1'b1, ADR_AMOUNT, am);
      bus(1'b1, ADR_CSW, {fl, 28'h0});
      bus(1'b1, ADR_INSTR, ins);
      do begin
         @(posedge clk_i);
         n++;
      end while (done !== 1'b1 && n < 20);
      if (n >= 20) err_total++;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] mk(input logic [3:0] cn, input logic i, input logic [3:0] o,
      input logic s, input logic [3:0] rn, input logic [3:0] rd, input logic [11:0] o2);
      return {cn, 2'b00, i, o, s, rn, rd, o2};
   endfunction
   function automatic logic [11:0] si(input logic [4:0] am, input dpa_shift_t ty);
      return {am, ty, 1'b0, 4'h2};
   endfunction
   function automatic logic [11:0] sr(input dpa_shift_t ty);
      return {4'h4, 1'b0, ty, 1'b1, 4'h2};
   endfunction
   // logical ops see the shifter carry, here the old carry of a zero shift
   function automatic logic [35:0] ref_op(input logic [3:0] o, input logic [31:0] x, y,
      input logic [3:0] fl);
      logic [31:0] p, u, r;
      logic [32:0] s;
      logic        ar;
      ar = o[3:2] == 2'b01 || o[3:1] == 3'b001 || o[3:1] == 3'b101;
      p = (o == 4'h3 || o == 4'h7) ? y : x;
      u = (o == 4'h4 || o == 4'h5 || o == 4'hb) ? y : ((o == 4'h3 || o == 4'h7) ? ~x : ~y);
      s = {1'b0, p} + {1'b0, u} + ((o == 4'h2 || o == 4'h3 || o == 4'ha) ? 33'h1 :
          ((o == 4'h5 || o == 4'h6 || o == 4'h7) ? {32'h0, fl[1]} : 33'h0));
      case (o)
         4'h0, 4'h8: r = x & y;
         4'h1, 4'h9: r = x ^ y;
         4'hc: r = x | y;
         4'hd: r = y;
         4'he: r = x & ~y;
         4'hf: r = ~y;
         default: r = s[31:0];
      endcase
      return {r[31], r == 32'h0, ar ? s[32] : fl[1],
              ar ? (p[31] == u[31] && s[31] != p[31]) : fl[0], r};
   endfunction
   task automatic sh(input logic i, input logic [11:0] o2, input logic [31:0] am, y,
      input logic ci, input logic [31:0] res, input logic c);
      setup(mk(4'he, i, 4'hd, 1'b1, 4'h1, 4'h3, o2), 32'h0, y, am, {2'b00, ci, 1'b1});
      rd(ADR_RESULT, res);
      rd(ADR_CSW, {res[31], res == 32'h0, c, 1'b1, 28'h0});
   endtask
   task automatic complete_run;
      if (err_total == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #2_000_000;
      err_total++;
      complete_run();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_i, cyc, stb, we, adr, dat} = {1'b1, 43'h0};
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADR_CSW, CSW_RST);
      rd(8'h40, 32'h0);
      for (k = 0; k < 32; k++) begin
         a = $random(seed);
         b = (k % 8 == 7) ? a : $random(seed);
         f = $random(seed);
         op = k[3:0];
         sb = k[4] || op[3:2] == 2'b10;
         e = ref_op(op, a, b, f);
         setup(mk(4'he, 1'b0, op, sb, 4'h1, 4'h3, si(5'd0, logical_left_shift)), a, b, 0, f);
         if (op[3:2] != 2'b10) rd(ADR_RESULT, e[31:0]);
         rd(ADR_CSW, {sb ? e[35:32] : f, 28'h0});
      end
      sh(0, si(5'd4, logical_left_shift), 0, 32'h1000_000f, 0, 32'h0000_00f0, 1);
      sh(0, si(5'd0, logical_left_shift), 0, 32'h8000_0005, 1, 32'h8000_0005, 1);
      sh(0, si(5'd0, logical_right_shift), 0, 32'h8000_0001, 0, 32'h0, 1);
      sh(0, si(5'd0, arithmetic_right_shift), 0, 32'h8000_0000, 0, 32'hffff_ffff, 1);
      sh(0, si(5'd5, arithmetic_right_shift), 0, 32'h8000_0010, 0, 32'hfc00_0000, 1);
      sh(0, si(5'd0, rotate_right), 0, 32'h3, 1, 32'h8000_0001, 1);
      sh(0, si(5'd4, rotate_right), 0, 32'h1a, 0, 32'ha000_0001, 1);
      sh(0, sr(logical_left_shift), 32'h100, 32'h5, 1, 32'h5, 1);
      sh(0, sr(logical_right_shift), 32'h4, 32'hf8, 0, 32'hf, 1);
      sh(0, sr(logical_left_shift), 32'h20, 32'h1, 0, 32'h0, 1);
      sh(0, sr(logical_left_shift), 32'h21, 32'h1, 1, 32'h0, 0);
      sh(0, sr(logical_right_shift), 32'h20, 32'h8000_0000, 0, 32'h0, 1);
      sh(0, sr(arithmetic_right_shift), 32'h28, 32'h8000_0000, 0, 32'hffff_ffff, 1);
      sh(0, sr(rotate_right), 32'h20, 32'h8000_0001, 0, 32'h8000_0001, 1);
      sh(0, sr(rotate_right), 32'h44, 32'h1a, 0, 32'ha000_0001, 1);
      sh(1, 12'h103, 0, 32'h0, 0, 32'hc000_0000, 1);
      bus(1'b1, ADR_PC, 32'h100);
      setup(mk(4'he, 0, op_add, 0, 4'hf, 4'h3, si(5'd0, logical_left_shift)), 0, 5, 0, 0);
      rd(ADR_RESULT, 32'h10d);
      setup(mk(4'he, 0, op_add, 0, 4'hf, 4'h3, sr(logical_left_shift)), 0, 5, 0, 0);
      rd(ADR_RESULT, 32'h111);
      setup(mk(4'h0, 0, pass_operand_op, 1, 4'h1, 4'h3, 12'h002), 0, 32'h77, 0, 4'h0);
      rd(ADR_RESULT, 32'h111);
      rd(ADR_CSW, 32'h0);
      setup(mk(4'h0, 0, pass_operand_op, 1, 4'h1, 4'h3, 12'h002), 0, 32'h77, 0, 4'h4);
      rd(ADR_RESULT, 32'h77);
      setup(mk(4'he, 0, pass_operand_op, 1, 4'h1, 4'h3, 12'h492), 0, 32'h99, 0, 4'h4);
      rd(ADR_RESULT, 32'h77);
      rd(ADR_CSW, 32'h4000_0000);
      bus(1'b1, ADR_SSW, 32'ha000_0000);
      setup(mk(4'he, 0, pass_operand_op, 1, 4'h1, 4'hf, 12'h002), 0, 32'h240, 0, 4'h0);
      rd(ADR_PC, 32'h240);
      rd(ADR_CSW, 32'ha000_0000);
      repeat (2) @(posedge clk_i);
      complete_run();
   end
endmodule
